// ### include/acs_pkg.sv
// Shared constants and types for the converter serial port and calibration
package acs_pkg;

    // ==========================================================
    // Word format
    localparam int ACS_WORD_W = 16;
    localparam logic [4:0] ACS_LAST_BIT = 5'h0F;
    localparam logic [15:0] ACS_TEST_RESTORE_WORD = 16'h4002;
    localparam logic ACS_MODE_RST = 1'b0;

    // ==========================================================
    // Timing
    localparam int ACS_CLK_PERIOD_NS = 40;
    localparam int ACS_INPUT_SETTLE_TIME_NS = 100;
    localparam int ACS_INPUT_SETTLE_CYC =
        (ACS_INPUT_SETTLE_TIME_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
    localparam int ACS_LINE_TURNAROUND_DELAY_NS = 80;
    localparam int ACS_TURN_RAW =
        (ACS_LINE_TURNAROUND_DELAY_NS + ACS_CLK_PERIOD_NS - 1)
        / ACS_CLK_PERIOD_NS;
    localparam int ACS_TURN_CYC = (ACS_TURN_RAW < 1) ? 1 : ACS_TURN_RAW;
    // Calibration step lengths in clock cycles
    localparam int ACS_TRIM_CYC = 1024;
    localparam int ACS_GAIN_CYC = 256;
    localparam int ACS_OFFSET_CYC = 256;

    // ==========================================================
    // Pin synchroniser
    localparam int ACS_PIN_N = 5;

    typedef struct packed {
        logic sclk;
        logic frame_n;
        logic sdata;
        logic cal_n;
        logic conv_n;
    } acs_pins_t;

    typedef struct packed {
        logic strobe_fall;
        logic strobe_rise;
        logic sw_start;
        logic conv_rise;
    } acs_cal_ev_t;

    // ==========================================================
    // Calibration types and sequencer states
    typedef enum logic [1:0] {
        ACS_CAL_FULL = 2'h0,
        ACS_CAL_GAIN_OFFS = 2'h1,
        ACS_CAL_OFFSET = 2'h2,
        ACS_CAL_GAIN = 2'h3
    } acs_cal_type_t;

    typedef enum logic [2:0] {
        ACS_ST_IDLE = 3'h0,
        ACS_ST_ARM = 3'h1,
        ACS_ST_TRIM = 3'h3,
        ACS_ST_GAIN = 3'h2,
        ACS_ST_WAIT = 3'h6,
        ACS_ST_OFFS = 3'h7,
        ACS_ST_SINGLE = 3'h5
    } acs_cal_state_t;

endpackage

// ### design/acs_cal_seq.sv
// System calibration sequencer with busy reporting
`timescale 1ns/1ps
module acs_cal_seq #(
    parameter int TRIM_CYC = acs_pkg::ACS_TRIM_CYC,
    parameter int GAIN_CYC = acs_pkg::ACS_GAIN_CYC,
    parameter int OFFSET_CYC = acs_pkg::ACS_OFFSET_CYC
) (
    input wire logic clock_i,                        // System clock
    input wire logic rst_n_i,                        // Sync reset, low
    input wire logic clk_en_i,                       // Clock enable
    input wire acs_pkg::acs_cal_ev_t cal_ev_i,       // Strobe/trigger events
    input wire acs_pkg::acs_cal_type_t cal_type_i,   // Selected sequence
    output logic busy_o,                             // Busy level
    output logic int_reset_o,                        // Internal reset pulse
    output acs_pkg::acs_cal_state_t state_o          // Sequencer state
);
    import acs_pkg::*;

    acs_cal_state_t st_r, st_nxt;
    acs_cal_type_t type_r, type_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic int_rst_r, int_rst_nxt;
    logic done;

    // First busy state for a sequence type
    function automatic acs_cal_state_t first_state(acs_cal_type_t t);
        unique case (t)
            ACS_CAL_FULL: first_state = ACS_ST_TRIM;
            ACS_CAL_GAIN_OFFS: first_state = ACS_ST_GAIN;
            ACS_CAL_OFFSET: first_state = ACS_ST_SINGLE;
            ACS_CAL_GAIN: first_state = ACS_ST_SINGLE;
        endcase
    endfunction

    // Length of that first busy state
    function automatic logic [15:0] first_len(acs_cal_type_t t);
        unique case (t)
            ACS_CAL_FULL: first_len = 16'(TRIM_CYC);
            ACS_CAL_GAIN_OFFS: first_len = 16'(GAIN_CYC);
            ACS_CAL_OFFSET: first_len = 16'(OFFSET_CYC);
            ACS_CAL_GAIN: first_len = 16'(GAIN_CYC);
        endcase
    endfunction

    assign done = (cnt_r == 16'h0001);

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        type_nxt = type_r;
        cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
        int_rst_nxt = 1'b0;
        if (cal_ev_i.strobe_fall) begin
            st_nxt = ACS_ST_ARM;
            int_rst_nxt = 1'b1;
            cnt_nxt = 16'h0000;
        end else begin
            unique case (st_r)
                ACS_ST_IDLE: begin
                    if (cal_ev_i.sw_start) begin
                        st_nxt = first_state(cal_type_i);
                        cnt_nxt = first_len(cal_type_i);
                        type_nxt = cal_type_i;
                    end
                end
                ACS_ST_ARM: begin
                    if (cal_ev_i.strobe_rise) begin
                        st_nxt = first_state(cal_type_i);
                        cnt_nxt = first_len(cal_type_i);
                        type_nxt = cal_type_i;
                    end
                end
                ACS_ST_TRIM: begin
                    if (done) begin
                        st_nxt = ACS_ST_GAIN;
                        cnt_nxt = 16'(GAIN_CYC);
                    end
                end
                ACS_ST_GAIN: begin
                    if (done) begin
                        st_nxt = ACS_ST_WAIT;
                    end
                end
                ACS_ST_WAIT: begin
                    if (cal_ev_i.conv_rise) begin
                        st_nxt = ACS_ST_OFFS;
                        cnt_nxt = 16'(OFFSET_CYC);
                    end
                end
                ACS_ST_OFFS: begin
                    if (done) begin
                        st_nxt = ACS_ST_IDLE;
                    end
                end
                ACS_ST_SINGLE: begin
                    if (done) begin
                        st_nxt = ACS_ST_IDLE;
                    end
                end
                default: st_nxt = ACS_ST_IDLE;
            endcase
        end
        busy_nxt = (st_nxt == ACS_ST_TRIM) || (st_nxt == ACS_ST_GAIN) ||
                   (st_nxt == ACS_ST_OFFS) || (st_nxt == ACS_ST_SINGLE);
    end

    // Registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= ACS_ST_IDLE;
            type_r <= ACS_CAL_FULL;
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            int_rst_r <= 1'b0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
            type_r <= type_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            int_rst_r <= int_rst_nxt;
        end
    end

    assign busy_o = busy_r;
    assign int_reset_o = int_rst_r;
    assign state_o = st_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i || !clk_en_i);

    chk_reset_on_fall: assert property (
        cal_ev_i.strobe_fall |=> int_rst_r && st_r == ACS_ST_ARM && !busy_r)
        else $error("strobe fall did not reset sequencer");
    chk_busy_on_rise: assert property (
        (st_r == ACS_ST_ARM && cal_ev_i.strobe_rise && !cal_ev_i.strobe_fall)
        |=> busy_r)
        else $error("busy not raised on strobe rise");
    chk_gain_then_low: assert property (
        (st_r == ACS_ST_GAIN && done && !cal_ev_i.strobe_fall)
        |=> !busy_r && st_r == ACS_ST_WAIT)
        else $error("busy not lowered after gain step");
    chk_offset_start: assert property (
        (st_r == ACS_ST_WAIT && cal_ev_i.conv_rise && !cal_ev_i.strobe_fall)
        |=> busy_r && st_r == ACS_ST_OFFS && cnt_r == 16'(OFFSET_CYC))
        else $error("offset step not started by trigger");
    chk_skip_trim: assert property (
        (st_r == ACS_ST_ARM && cal_ev_i.strobe_rise &&
         !cal_ev_i.strobe_fall && cal_type_i == ACS_CAL_GAIN_OFFS)
        |=> st_r == ACS_ST_GAIN && cnt_r == 16'(GAIN_CYC))
        else $error("gain plus offset did not skip trim");
    chk_single_busy: assert property (
        (st_r == ACS_ST_SINGLE && !done && !cal_ev_i.strobe_fall) |=> busy_r)
        else $error("busy dropped during single calibration");

    cov_full_seq: cover property (st_r == ACS_ST_WAIT ##[1:1000]
        st_r == ACS_ST_OFFS);
    cov_single_done: cover property (st_r == ACS_ST_SINGLE ##1
        st_r == ACS_ST_IDLE);
endmodule

// ### design/acs_serial_port.sv
// Converter serial port top with calibration sequencer
`timescale 1ns/1ps
module acs_serial_port #(
    parameter int TRIM_CYC = acs_pkg::ACS_TRIM_CYC,
    parameter int GAIN_CYC = acs_pkg::ACS_GAIN_CYC,
    parameter int OFFSET_CYC = acs_pkg::ACS_OFFSET_CYC
) (
    input wire logic clock_i,                      // 25 MHz clock
    input wire logic rst_n_i,                      // Sync reset, low
    input wire logic clk_en_i,                     // Clock enable
    input wire logic sclk_i,                       // Serial clock pin
    input wire logic frame_n_i,                    // Frame select, low
    input wire logic sdin_i,                       // Data in / shared line
    input wire logic cal_n_i,                      // Calibration strobe
    input wire logic convert_trigger_n_i,          // Conversion trigger
    input wire logic ctl_wr_i,                     // Control write pulse
    input wire logic ctl_two_wire_i,               // Two-wire select bit
    input wire acs_pkg::acs_cal_type_t ctl_cal_type_i, // Calibration type
    input wire logic ctl_cal_start_i,              // Software cal start
    input wire logic cal_rd_seq_i,                 // Cal register read
    input wire logic cal_wr_seq_i,                 // Cal register write
    input wire logic [15:0] tx_word_i,             // Word to shift out
    output logic sdout_o,                          // Three-wire data out
    output logic sdout_oe_o,                       // Data out enable
    output logic sdin_o,                           // Shared line out
    output logic sdin_oe_o,                        // Shared line enable
    output logic [15:0] rx_word_o,                 // Received word
    output logic rx_valid_o,                       // Word received pulse
    output logic test_restore_o,                   // Test reg restore
    output logic two_wire_o,                       // Two-wire mode
    output logic busy_o,                           // Busy level
    output logic int_reset_o                       // Internal reset
);
    import acs_pkg::*;

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [ACS_PIN_N-1:0] pin_raw;
    logic [ACS_PIN_N-1:0] sync1_r;
    logic [ACS_PIN_N-1:0] sync2_r;
    logic [ACS_PIN_N-1:0] prev_r;
    acs_pins_t pin_s;
    acs_pins_t pin_p;

    assign pin_raw = {sclk_i, frame_n_i, sdin_i, cal_n_i,
                      convert_trigger_n_i};

    // Two-stage synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < ACS_PIN_N; gi++) begin : g_sync
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                    prev_r[gi] <= 1'b1;
                end else if (clk_en_i) begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    assign pin_s = acs_pins_t'(sync2_r);
    assign pin_p = acs_pins_t'(prev_r);

    logic sclk_rise, sclk_fall, frame_fall, frame_hi;
    acs_cal_ev_t cal_ev;

    // Edge events
    assign sclk_rise = pin_s.sclk & ~pin_p.sclk;
    assign sclk_fall = ~pin_s.sclk & pin_p.sclk;
    assign frame_fall = ~pin_s.frame_n & pin_p.frame_n;
    assign frame_hi = pin_s.frame_n;
    assign cal_ev.strobe_fall = ~pin_s.cal_n & pin_p.cal_n;
    assign cal_ev.strobe_rise = pin_s.cal_n & ~pin_p.cal_n;
    assign cal_ev.sw_start = ctl_cal_start_i;
    assign cal_ev.conv_rise = pin_s.conv_n & ~pin_p.conv_n;

    // ==========================================================
    // Calibration sequencer
    logic seq_busy, seq_int_rst;

    acs_cal_seq #(
        .TRIM_CYC(TRIM_CYC),
        .GAIN_CYC(GAIN_CYC),
        .OFFSET_CYC(OFFSET_CYC)
    ) u_seq (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .cal_ev_i(cal_ev),
        .cal_type_i(ctl_cal_type_i),
        .busy_o(seq_busy),
        .int_reset_o(seq_int_rst),
        .state_o()
    );

    // ==========================================================
    // Serial shifter state
    logic [15:0] rx_sh_r, rx_sh_nxt;
    logic [15:0] tx_sh_r, tx_sh_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic sdout_r, sdout_nxt;
    logic dir_out_r, dir_out_nxt;
    logic [7:0] turn_cnt_r, turn_cnt_nxt;
    logic mode_r, mode_nxt;
    logic [15:0] rx_word_r, rx_word_nxt;
    logic rx_valid_r, rx_valid_nxt;
    logic restore_r, restore_nxt;
    logic sdin_oe_r, sdin_oe_nxt;
    logic sdout_oe_r, sdout_oe_nxt;
    logic [15:0] word_in;

    assign word_in = {rx_sh_r[14:0], pin_s.sdata};

    // Next values of the shifter, direction and mode
    always_comb begin
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        bit_cnt_nxt = bit_cnt_r;
        sdout_nxt = sdout_r;
        dir_out_nxt = dir_out_r;
        turn_cnt_nxt = turn_cnt_r;
        rx_word_nxt = rx_word_r;
        rx_valid_nxt = 1'b0;
        restore_nxt = 1'b0;
        // Mode changes only on a control write
        mode_nxt = ctl_wr_i ? ctl_two_wire_i : mode_r;
        if (!mode_nxt) begin
            dir_out_nxt = 1'b0;
            turn_cnt_nxt = 8'h00;
        end
        // Turnaround back to input
        if (turn_cnt_r != 8'h00) begin
            turn_cnt_nxt = turn_cnt_r - 8'h01;
            if (turn_cnt_r == 8'h01) begin
                dir_out_nxt = 1'b0;
            end
        end
        if (frame_hi) begin
            rx_sh_nxt = 16'h0000;
            tx_sh_nxt = 16'h0000;
            bit_cnt_nxt = 5'h00;
        end else begin
            // Sample on rising serial clock
            if (sclk_rise) begin
                rx_sh_nxt = word_in;
                bit_cnt_nxt = bit_cnt_r + 5'h01;
                if (bit_cnt_r == ACS_LAST_BIT) begin
                    bit_cnt_nxt = 5'h00;
                    tx_sh_nxt = tx_word_i;
                    if (!(mode_r && dir_out_r)) begin
                        rx_word_nxt = word_in;
                        rx_valid_nxt = 1'b1;
                        restore_nxt = (word_in == ACS_TEST_RESTORE_WORD);
                    end
                    if (mode_r && !dir_out_r && !cal_wr_seq_i) begin
                        dir_out_nxt = 1'b1;
                    end else if (mode_r && dir_out_r && !cal_rd_seq_i) begin
                        turn_cnt_nxt = 8'(ACS_TURN_CYC);
                    end
                end
            end
            // Shift out on frame fall or falling serial clock
            if (frame_fall) begin
                tx_sh_nxt = tx_word_i;
                if (!pin_s.sclk) begin
                    sdout_nxt = tx_word_i[15];
                    tx_sh_nxt = {tx_word_i[14:0], 1'b0};
                end
            end else if (sclk_fall) begin
                sdout_nxt = tx_sh_r[15];
                tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
            end
        end
        // Drivers float while frame select is high
        sdin_oe_nxt = mode_nxt & dir_out_nxt & ~frame_hi;
        sdout_oe_nxt = ~mode_nxt & ~frame_hi;
    end

    // Shifter registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_sh_r <= 16'h0000;
            tx_sh_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            sdout_r <= 1'b0;
            dir_out_r <= 1'b0;
            turn_cnt_r <= 8'h00;
            mode_r <= ACS_MODE_RST;
            rx_word_r <= 16'h0000;
            rx_valid_r <= 1'b0;
            restore_r <= 1'b0;
            sdin_oe_r <= 1'b0;
            sdout_oe_r <= 1'b0;
        end else if (clk_en_i) begin
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sdout_r <= sdout_nxt;
            dir_out_r <= dir_out_nxt;
            turn_cnt_r <= turn_cnt_nxt;
            mode_r <= mode_nxt;
            rx_word_r <= rx_word_nxt;
            rx_valid_r <= rx_valid_nxt;
            restore_r <= restore_nxt;
            sdin_oe_r <= sdin_oe_nxt;
            sdout_oe_r <= sdout_oe_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign sdout_o = sdout_r;
    assign sdin_o = sdout_r;
    assign sdout_oe_o = sdout_oe_r;
    assign sdin_oe_o = sdin_oe_r;
    assign rx_word_o = rx_word_r;
    assign rx_valid_o = rx_valid_r;
    assign test_restore_o = restore_r;
    assign two_wire_o = mode_r;
    assign busy_o = seq_busy;
    assign int_reset_o = seq_int_rst;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i || !clk_en_i);

    chk_frame_clear: assert property (
        frame_hi |=> bit_cnt_r == 5'h00 && rx_sh_r == 16'h0000)
        else $error("frame high did not clear shifter");
    chk_msb_on_frame: assert property (
        (frame_fall && !pin_s.sclk) |=> sdout_r == $past(tx_word_i[15]))
        else $error("msb not shifted on frame fall");
    chk_float_high: assert property (
        frame_hi |=> !sdin_oe_r && !sdout_oe_r)
        else $error("driver active while frame high");
    chk_restore_word: assert property (
        (rx_valid_r && rx_word_r == ACS_TEST_RESTORE_WORD) |-> restore_r)
        else $error("restore word not flagged");
    chk_mode_entry: assert property (
        !ctl_wr_i |=> mode_r == $past(mode_r))
        else $error("mode changed without control write");
    chk_line_turn: assert property (
        (mode_r && turn_cnt_r == 8'h01 && ctl_wr_i == 1'b0) |=> !dir_out_r)
        else $error("shared line not returned to input");
    chk_drive_after: assert property (
        (mode_r && !dir_out_r && !cal_wr_seq_i && !frame_hi && sclk_rise &&
         bit_cnt_r == ACS_LAST_BIT && !ctl_wr_i) |=> dir_out_r)
        else $error("shared line not turned to output");

    cov_restore: cover property (rx_valid_r && restore_r);
    cov_turnaround: cover property (dir_out_r ##[1:1000] !dir_out_r);
    cov_busy: cover property (seq_busy ##[1:1000] !seq_busy);
endmodule

// ### bench/acs_host_model.sv
// Host serial master model: clock, frame select and data to the device
`timescale 1ns/1ps
module acs_host_model (
    input wire logic clock_i,   // System clock for pacing
    input wire logic rx_i,      // Data coming from the device
    output logic sclk_o,        // Serial clock, idles high
    output logic frame_n_o,     // Frame select, active low
    output logic tx_o           // Data going to the device
);
    // ==========================================================
    // Idle levels between frames
    initial begin
        sclk_o = 1'b1;
        frame_n_o = 1'b1;
        tx_o = 1'b0;
    end
    // Half of the 320 ns serial period
    task automatic half();
        repeat (4) @(negedge clock_i);
    endtask
    // One framed transfer of n bits, MSB first, clock stopped outside
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] got);
        got = 16'h0000;
        frame_n_o = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            tx_o = w[15 - i];
            half();
            sclk_o = 1'b1;
            half();
            got = {got[14:0], rx_i};
        end
        frame_n_o = 1'b1;
        tx_o = ~tx_o; // Released line shows a changed level
        half();
    endtask
endmodule

// ### bench/acs_serial_port_bench.sv
// Self-checking bench for the serial port and calibration sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module acs_serial_port_bench;
    import acs_pkg::*;
    localparam int TRIM = 12;
    localparam int GAIN = 8;
    localparam int OFFS = 6;
    logic clock_i = 0, rst_n_i = 0, cal_n_i = 1, conv_n = 1;
    logic ctl_wr = 0, ctl_two = 0, ctl_start = 0, host_tx, sclk, frame_n;
    acs_cal_type_t cal_type = ACS_CAL_FULL;
    logic [15:0] tx_word = 16'hA5C3, rx_word, got;
    logic sdout, sdout_oe, sd_o, sd_oe, rx_valid, restore, two_wire;
    logic busy, int_rst, line;
    int err_count = 0, n_compared = 0, n_rx = 0, n_rst = 0, n_ires = 0;
    int busy_len = 0, cyc = 0, k;

    // ==========================================================
    // Shared data line and instances
    assign line = sd_oe ? sd_o : host_tx;
    acs_serial_port #(.TRIM_CYC(TRIM), .GAIN_CYC(GAIN), .OFFSET_CYC(OFFS))
    i_acs_serial_port (.clock_i, .rst_n_i, .clk_en_i(1'b1), .sclk_i(sclk),
        .frame_n_i(frame_n), .sdin_i(line), .cal_n_i,
        .convert_trigger_n_i(conv_n), .ctl_wr_i(ctl_wr),
        .ctl_two_wire_i(ctl_two), .ctl_cal_type_i(cal_type),
        .ctl_cal_start_i(ctl_start), .cal_rd_seq_i(1'b0), .cal_wr_seq_i(1'b0),
        .tx_word_i(tx_word), .sdout_o(sdout), .sdout_oe_o(sdout_oe),
        .sdin_o(sd_o), .sdin_oe_o(sd_oe), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid), .test_restore_o(restore),
        .two_wire_o(two_wire), .busy_o(busy), .int_reset_o(int_rst));
    acs_host_model i_acs_host_model (.clock_i, .rx_i(two_wire ? line : sdout),
        .sclk_o(sclk), .frame_n_o(frame_n), .tx_o(host_tx));

    // ==========================================================
    // Verdict and end of run
    task automatic final_report();
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always #20 clock_i = ~clock_i;
    // Event counters, busy length and hang limit
    always @(posedge clock_i) begin
        cyc++;
        if (rx_valid) n_rx++;
        if (restore) n_rst++;
        if (int_rst) n_ires++;
        if (busy) busy_len++;
        if (cyc > 20000) begin
            err_count++;
            final_report();
        end
    end
    // Waits out one busy phase and checks its length
    task automatic busy_phase(input int exp);
        busy_len = 0;
        for (int i = 0; i < 40 && !busy; i++) @(negedge clock_i);
        for (int i = 0; i < 400 && busy; i++) @(negedge clock_i);
        `CHK(busy_len, exp)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_three_wire();
        `CHK(two_wire, 1'b0)
        i_acs_host_model.xfer(16'h4002, 16, got);
        `CHK(got, tx_word)
        `CHK(rx_word, 16'h4002)
        `CHK(n_rst, 1)
    endtask
    task automatic t_abort();
        i_acs_host_model.xfer(16'hFFFF, 5, got);
        i_acs_host_model.xfer(16'h1234, 16, got);
        `CHK(rx_word, 16'h1234)
        `CHK(n_rx, 2)
        `CHK(got, tx_word)
    endtask
    task automatic t_soft_offset();
        cal_type = ACS_CAL_OFFSET;
        ctl_start = 1'b1;
        @(negedge clock_i);
        ctl_start = 1'b0;
        busy_phase(OFFS);
    endtask
    task automatic t_strobe(input acs_cal_type_t t, input int a, input int b);
        cal_type = t;
        k = n_ires;
        cal_n_i = 1'b0;
        repeat (8) @(negedge clock_i);
        `CHK(n_ires - k, 1)
        cal_n_i = 1'b1;
        busy_phase(a);
        conv_n = 1'b0;
        repeat (4) @(negedge clock_i);
        conv_n = 1'b1;
        busy_phase(b);
    endtask
    task automatic t_two_wire();
        ctl_two = 1'b1;
        ctl_wr = 1'b1;
        @(negedge clock_i);
        ctl_wr = 1'b0;
        @(negedge clock_i);
        `CHK(two_wire, 1'b1)
        conv_n = 1'b0;
        repeat (4) @(negedge clock_i);
        conv_n = 1'b1;
        repeat (6) @(negedge clock_i);
        `CHK(busy, 1'b0)
        `CHK(sdout_oe, 1'b0)
        i_acs_host_model.xfer(16'h0F0F, 16, got);
        `CHK(rx_word, 16'h0F0F)
        `CHK(sd_oe, 1'b0)
        i_acs_host_model.xfer(16'h0000, 16, got);
        `CHK(got, tx_word)
        repeat (4) @(negedge clock_i);
        `CHK(sd_oe, 1'b0)
        `CHK(n_rx, 3)
    endtask

    // Main sequence
    initial begin
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        t_three_wire();
        t_abort();
        t_soft_offset();
        t_strobe(ACS_CAL_FULL, TRIM + GAIN, OFFS);
        t_strobe(ACS_CAL_GAIN_OFFS, GAIN, OFFS);
        t_strobe(ACS_CAL_GAIN, GAIN, 0);
        t_two_wire();
        final_report();
    end
endmodule
